// File: hisc_top.v
`timescale 1ns/10ps
`include "hisc_consts.vh"
module hisc_top #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3,
  parameter INIT_CYCLES = `HISC_INIT_CYCLES,
  parameter DAC_SAVE_CYCLES = `HISC_DAC_SAVE_CYCLES
) (
  // Clock and reset
  input wire ref_clk,
  input wire resetn,
  // Interface select strap
  input wire strap_sel,
  // Shared pin 1: two-wire data or chip select
  input wire pin1_in,
  output reg pin1_out,
  output reg pin1_oe,
  // Shared pin 2: two-wire clock or serial clock
  input wire pin2_in,
  output reg pin2_out,
  output reg pin2_oe,
  // Shared pin 3: serial transmit or target output
  output reg pin3_out,
  output reg pin3_oe,
  // Shared pin 4: serial receive or target input
  input wire pin4_in,
  // Selection status
  output reg sel_done,
  output reg spi_mode,
  output reg spi_ready,
  // Two-wire port user side
  input wire tw_sda_low,
  input wire tw_scl_hold,
  output reg tw_sda_in,
  output reg tw_scl_in,
  // Serial port user side
  input wire uart_txd,
  output reg uart_rxd,
  // SPI user side
  input wire glitch_filter_en,
  input wire tx_valid,
  output wire tx_ready,
  input wire [7:0] tx_data,
  output reg rx_valid,
  output reg [7:0] rx_data,
  // Configuration
  input wire cfg_wr_valid,
  input wire [15:0] cfg_wr_data,
  output reg [15:0] cfg_active,
  input wire tmode_wr_valid,
  input wire [1:0] tmode_wr_data,
  input wire survey_done,
  output reg [1:0] tmode_state,
  input wire config_save_command,
  // Oscillator control values
  input wire [15:0] dac_int_val,
  input wire [15:0] dac_ext_val,
  // Flash image at boot
  input wire flash_cfg_valid,
  input wire [15:0] flash_cfg_data,
  input wire [1:0] flash_tmode_data,
  // Flash write port
  output reg flash_wr_req,
  output reg flash_wr_kind,
  output reg [31:0] flash_wr_data,
  input wire flash_wr_ack
);
  // Pin synchronisers
  reg strap_meta;
  reg strap_sync;
  reg [2:0] pin_meta;
  reg [2:0] pin_sync;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      strap_meta <= 1'b1;
      strap_sync <= 1'b1;
      pin_meta <= 3'h7;
      pin_sync <= 3'h7;
    end else begin
      strap_meta <= strap_sel;
      strap_sync <= strap_meta;
      pin_meta <= {pin4_in, pin2_in, pin1_in};
      pin_sync <= pin_meta;
    end
  end

  // Strap capture once after reset release
  reg [1:0] settle;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      settle <= 2'h0;
      sel_done <= 1'b0;
      spi_mode <= 1'b0;
    end else if (!sel_done) begin
      settle <= settle + 2'h1;
      if (settle == `HISC_STRAP_SETTLE) begin
        sel_done <= 1'b1;
        spi_mode <= ~strap_sync;
      end
    end
  end

  // SPI target held off for the initialization time
  reg [23:0] init_cnt;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      init_cnt <= 24'h000000;
      spi_ready <= 1'b0;
    end else if (sel_done && spi_mode && !spi_ready) begin
      if (init_cnt == INIT_CYCLES - 1) begin
        spi_ready <= 1'b1;
      end else begin
        init_cnt <= init_cnt + 24'h000001;
      end
    end
  end

  // Serial clock filter and edge detect
  reg sclk_hold;
  reg sclk_lvl;
  reg sclk_prev;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sclk_hold <= 1'b0;
      sclk_lvl <= 1'b0;
      sclk_prev <= 1'b0;
    end else begin
      sclk_hold <= pin_sync[1];
      if (!glitch_filter_en || pin_sync[1] == sclk_hold) begin
        sclk_lvl <= pin_sync[1];
      end
      sclk_prev <= sclk_lvl;
    end
  end
  wire sclk_rise = sclk_lvl & ~sclk_prev;
  wire cs_act = spi_mode & spi_ready & ~pin_sync[0];

  // Transmit FIFO
  wire fifo_valid;
  wire [7:0] fifo_data;
  reg loaded;
  wire fifo_pop = cs_act & ~loaded & fifo_valid;
  hisc_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_tx_fifo (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // SPI shift engine, mode 0, most significant bit first
  reg [7:0] tx_sh;
  reg [7:0] rx_sh;
  reg [2:0] bit_cnt;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_sh <= `HISC_SPI_FILL;
      rx_sh <= 8'h00;
      bit_cnt <= 3'h0;
      loaded <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
    end else begin
      rx_valid <= 1'b0;
      if (!cs_act) begin
        bit_cnt <= 3'h0;
        loaded <= 1'b0;
      end else if (!loaded) begin
        tx_sh <= fifo_valid ? fifo_data : `HISC_SPI_FILL;
        loaded <= 1'b1;
      end else if (sclk_rise) begin
        // Output bit advances after the sampling edge: one period of margin less the synchroniser, edge-detect and pin register delay
        rx_sh <= {rx_sh[6:0], pin_sync[2]};
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7) begin
          rx_data <= {rx_sh[6:0], pin_sync[2]};
          rx_valid <= 1'b1;
          loaded <= 1'b0;
        end else begin
          tx_sh <= {tx_sh[6:0], 1'b1};
        end
      end
    end
  end

  // Pin routing
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pin1_out <= 1'b0;
      pin1_oe <= 1'b0;
      pin2_out <= 1'b0;
      pin2_oe <= 1'b0;
      pin3_out <= 1'b1;
      pin3_oe <= 1'b0;
      tw_sda_in <= 1'b1;
      tw_scl_in <= 1'b1;
      uart_rxd <= 1'b1;
    end else if (!sel_done) begin
      pin1_oe <= 1'b0;
      pin2_oe <= 1'b0;
      pin3_oe <= 1'b0;
    end else if (spi_mode) begin
      pin1_oe <= 1'b0;
      pin2_oe <= 1'b0;
      pin3_out <= tx_sh[7];
      pin3_oe <= cs_act & loaded;
      tw_sda_in <= 1'b1;
      tw_scl_in <= 1'b1;
      uart_rxd <= 1'b1;
    end else begin
      pin1_out <= 1'b0;
      pin1_oe <= tw_sda_low;
      pin2_out <= 1'b0;
      pin2_oe <= tw_scl_hold;
      pin3_out <= uart_txd;
      pin3_oe <= 1'b1;
      tw_sda_in <= pin_sync[0];
      tw_scl_in <= pin_sync[1];
      uart_rxd <= pin_sync[2];
    end
  end

  // Volatile configuration and timing mode
  reg boot;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      boot <= 1'b1;
      cfg_active <= `HISC_CFG_RESET;
      tmode_state <= `HISC_TMODE_OFF;
    end else if (boot) begin
      boot <= 1'b0;
      if (flash_cfg_valid) begin
        cfg_active <= flash_cfg_data;
        tmode_state <= flash_tmode_data;
      end
    end else begin
      if (cfg_wr_valid) begin
        cfg_active <= cfg_wr_data;
      end
      if (tmode_wr_valid) begin
        tmode_state <= tmode_wr_data;
      end else if (survey_done &&
                   tmode_state == `HISC_TMODE_SURVEY) begin
        tmode_state <= `HISC_TMODE_FIXED;
      end
    end
  end

  // Save requests and automatic oscillator save timer
  reg save_pend;
  reg [15:0] save_cfg;
  reg [1:0] save_tmode;
  reg dac_pend;
  reg [31:0] dac_cnt;
  wire launch = ~flash_wr_req & ~boot & (save_pend | dac_pend);
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      save_pend <= 1'b0;
      save_cfg <= `HISC_CFG_RESET;
      save_tmode <= `HISC_TMODE_OFF;
      dac_pend <= 1'b0;
      dac_cnt <= 32'h00000000;
    end else begin
      if (config_save_command) begin
        save_pend <= 1'b1;
        save_cfg <= cfg_active;
        save_tmode <= tmode_state;
      end else if (launch && save_pend) begin
        save_pend <= 1'b0;
      end
      if (dac_cnt == DAC_SAVE_CYCLES - 1) begin
        dac_cnt <= 32'h00000000;
        dac_pend <= 1'b1;
      end else begin
        dac_cnt <= dac_cnt + 32'h00000001;
        if (launch && !save_pend) begin
          dac_pend <= 1'b0;
        end
      end
    end
  end

  // Flash write handshake
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      flash_wr_req <= 1'b0;
      flash_wr_kind <= `HISC_FLASH_CFG;
      flash_wr_data <= 32'h00000000;
    end else if (launch) begin
      flash_wr_req <= 1'b1;
      if (save_pend) begin
        flash_wr_kind <= `HISC_FLASH_CFG;
        flash_wr_data <= {14'h0000, save_tmode, save_cfg};
      end else begin
        flash_wr_kind <= `HISC_FLASH_DAC;
        flash_wr_data <= {dac_int_val, dac_ext_val};
      end
    end else if (flash_wr_req && flash_wr_ack) begin
      flash_wr_req <= 1'b0;
    end
  end
endmodule // hisc_top

// File: hisc_consts.vh
`ifndef HISC_CONSTS_VH
`define HISC_CONSTS_VH

// Clock rate in MHz
`define HISC_CLK_MHZ 25
// Host wait after startup before clocked transfers, in microseconds
`define HISC_T_INIT_US 500
`define HISC_INIT_CYCLES (`HISC_T_INIT_US * `HISC_CLK_MHZ)
// Host chip select deselect time, in microseconds
`define HISC_T_DES_US 1000
`define HISC_DES_CYCLES (`HISC_T_DES_US * `HISC_CLK_MHZ)
// Recommended serial clock bit rate, in kbit/s
`define HISC_SPI_KBPS 1000
// Two-wire port bit rate ceiling, in kbit/s
`define HISC_TW_KBPS 400
// Strap settle count after reset release
`define HISC_STRAP_SETTLE 2'h3
// Timing mode states
`define HISC_TMODE_OFF 2'h0
`define HISC_TMODE_SURVEY 2'h1
`define HISC_TMODE_FIXED 2'h2
// Reset values
`define HISC_CFG_RESET 16'h0000
`define HISC_SPI_FILL 8'hFF
// Flash write kinds
`define HISC_FLASH_CFG 1'h0
`define HISC_FLASH_DAC 1'h1
// Default period of the automatic oscillator setting save
`define HISC_DAC_SAVE_CYCLES 25000000

`endif

// File: hisc_fifo.v
`timescale 1ns/10ps
module hisc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire ref_clk,
  input wire resetn,
  // Fill side
  input wire in_valid,
  output reg in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output reg out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wptr;
  reg [AW-1:0] rptr;
  reg [AW:0] count;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire [AW:0] next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign out_data = mem[rptr];

  always @(posedge ref_clk) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wptr <= {AW{1'b0}};
      rptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wptr <= (wptr == DEPTH - 1) ? {AW{1'b0}} : wptr + 1'b1;
      end
      if (pop) begin
        rptr <= (rptr == DEPTH - 1) ? {AW{1'b0}} : rptr + 1'b1;
      end
      count <= next_count;
      in_ready <= (next_count != DEPTH);
      out_valid <= (next_count != {(AW+1){1'b0}});
    end
  end
endmodule // hisc_fifo

// File: hisc_monitor.sv
`timescale 1ns/10ps
`include "hisc_consts.vh"
module hisc_monitor (
  // Clock and reset
  input wire ref_clk,
  input wire resetn,
  // Pins and selection
  input wire pin1_oe,
  input wire pin2_oe,
  input wire sel_done,
  input wire spi_mode,
  input wire spi_ready,
  input wire tw_scl_hold,
  // Configuration
  input wire cfg_wr_valid,
  input wire [15:0] cfg_wr_data,
  input wire [15:0] cfg_active,
  input wire tmode_wr_valid,
  input wire survey_done,
  input wire [1:0] tmode_state,
  input wire config_save_command,
  // Flash write port
  input wire flash_wr_req,
  input wire flash_wr_kind,
  input wire [31:0] flash_wr_data,
  input wire flash_wr_ack
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  AST_SPI_PINS: assert property (
    spi_mode |-> !pin1_oe && !pin2_oe) else $error("spi pins driven");
  AST_NO_SPI_RDY: assert property (
    !spi_mode |-> !spi_ready) else $error("spi ready in two-wire mode");
  AST_TW_STRETCH: assert property (
    sel_done && !spi_mode && tw_scl_hold |=> pin2_oe)
    else $error("clock hold not driven");
  AST_SEL_FIXED: assert property (
    sel_done |=> sel_done && $stable(spi_mode)) else $error("mode moved");
  AST_CFG_WR: assert property (
    cfg_wr_valid |=> cfg_active == $past(cfg_wr_data))
    else $error("config write lost");
  AST_SURVEY: assert property (
    tmode_state == `HISC_TMODE_SURVEY && survey_done && !tmode_wr_valid
    |=> tmode_state == `HISC_TMODE_FIXED) else $error("survey not fixed");
  AST_SAVE_REQ: assert property (
    config_save_command |-> ##[1:40] flash_wr_req && !flash_wr_kind)
    else $error("save not launched");
  AST_REQ_HOLD: assert property (
    flash_wr_req && !flash_wr_ack |=> flash_wr_req && $stable(flash_wr_data))
    else $error("flash request dropped");
  AST_SAVE_TMODE: assert property (
    (config_save_command && !flash_wr_req) ##1 (flash_wr_req && !flash_wr_kind)
    |-> flash_wr_data[17:16] == $past(tmode_state))
    else $error("saved mode wrong");
endmodule // hisc_monitor
bind hisc_top hisc_monitor u_mon (.ref_clk, .resetn, .pin1_oe, .pin2_oe,
  .sel_done, .spi_mode, .spi_ready, .tw_scl_hold, .cfg_wr_valid, .cfg_wr_data,
  .cfg_active, .tmode_wr_valid, .survey_done, .tmode_state,
  .config_save_command, .flash_wr_req, .flash_wr_kind, .flash_wr_data,
  .flash_wr_ack);

// File: hisc_spi_host.sv
`timescale 1ns/10ps
module hisc_spi_host (
  // Host pins
  output reg cs_n,
  output reg sclk,
  output reg mosi,
  input wire miso
);
  // Half period of the 320 ns link clock, above the safe bit rate
  localparam HALF = 160;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  task frame_start;
    begin
      #500000;
      cs_n = 1'b0;
      #1000;
    end
  endtask
  task frame_end;
    begin
      #HALF;
      cs_n = 1'b1;
      mosi = ~mosi;
      #1000000;
    end
  endtask
  // Mode 0, MSB first; faster than the safe rate, filter on for the ninth byte only
  task xfer(input [7:0] tx, output [7:0] rx);
    integer i;
    for (i = 7; i >= 0; i = i - 1) begin
      mosi = tx[i];
      #HALF;
      sclk = 1'b1;
      rx[i] = miso;
      #HALF;
      sclk = 1'b0;
    end
  endtask
endmodule // hisc_spi_host

// File: hisc_top_tb.sv
`timescale 1ns/10ps
`include "hisc_consts.vh"
module hisc_top_tb;
  reg ref_clk = 1'b0, resetn = 1'b0, strap_sel = 1'b1, p1 = 1'b1, p4 = 1'b1;
  reg tw_sda_low = 1'b0, tw_scl_hold = 1'b0, uart_txd = 1'b1;
  reg glitch_filter_en = 1'b0, tx_valid = 1'b0, cfg_wr_valid = 1'b0;
  reg tmode_wr_valid = 1'b0, survey_done = 1'b0, config_save_command = 1'b0;
  reg flash_cfg_valid = 1'b0, flash_wr_ack = 1'b0;
  reg [7:0] tx_data = 8'h00;
  reg [15:0] cfg_wr_data = 16'h0000, flash_cfg_data = 16'h0000;
  reg [15:0] dac_int_val = 16'h1234, dac_ext_val = 16'hABCD;
  reg [1:0] tmode_wr_data = 2'h0, flash_tmode_data = `HISC_TMODE_OFF;
  wire pin1_out, pin1_oe, pin2_out, pin2_oe, pin3_out, pin3_oe, sel_done;
  wire spi_mode, spi_ready, tw_sda_in, tw_scl_in, uart_rxd, tx_ready;
  wire rx_valid, flash_wr_req, flash_wr_kind, cs_n, sclk, mosi;
  wire [7:0] rx_data;
  wire [15:0] cfg_active;
  wire [1:0] tmode_state;
  wire [31:0] flash_wr_data;
  wire pin1_in = spi_mode ? cs_n : p1 & ~pin1_oe;
  wire pin2_in = spi_mode ? sclk : ~pin2_oe;
  wire pin4_in = spi_mode ? mosi : p4;
  wire miso = pin3_oe ? pin3_out : ~pin3_out;
  logic [31:0] saved [0:1];
  logic [7:0] rxq [$];
  logic [7:0] b;
  int n_fail = 0;
  int n_compared = 0;
  int i;
  hisc_top #(.INIT_CYCLES(20), .DAC_SAVE_CYCLES(50)) u_dut (.ref_clk,
    .resetn, .strap_sel, .pin1_in, .pin1_out, .pin1_oe, .pin2_in, .pin2_out,
    .pin2_oe, .pin3_out, .pin3_oe, .pin4_in, .sel_done, .spi_mode, .spi_ready,
    .tw_sda_low, .tw_scl_hold, .tw_sda_in, .tw_scl_in, .uart_txd, .uart_rxd,
    .glitch_filter_en, .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_data,
    .cfg_wr_valid, .cfg_wr_data, .cfg_active, .tmode_wr_valid, .tmode_wr_data,
    .survey_done, .tmode_state, .config_save_command, .dac_int_val,
    .dac_ext_val, .flash_cfg_valid, .flash_cfg_data, .flash_tmode_data,
    .flash_wr_req, .flash_wr_kind, .flash_wr_data, .flash_wr_ack);
  hisc_spi_host u_host (.cs_n, .sclk, .mosi, .miso);
  always #20 ref_clk = ~ref_clk;
  // Flash acknowledges each write and keeps what it stored
  always @(posedge ref_clk) begin
    flash_wr_ack <= flash_wr_req && !flash_wr_ack;
    if (flash_wr_req && !flash_wr_ack)
      saved[flash_wr_kind] <= flash_wr_data;
    if (rx_valid === 1'b1)
      rxq.push_back(rx_data);
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task do_reset(input logic s);
    @(posedge ref_clk);
    resetn <= 1'b0;
    strap_sel <= s;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task give_verdict;
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #3000000;
    n_fail++;
    give_verdict;
  end
  initial begin
    saved[0] = 32'h0;
    saved[1] = 32'h0;
    do_reset(1'b1);
    chk("sel_done", 1, sel_done);
    chk("spi_mode", 0, spi_mode);
    chk("cfg_active", 16'h0000, cfg_active);
    @(posedge ref_clk);
    p1 <= 1'b0;
    p4 <= 1'b0;
    tw_scl_hold <= 1'b1;
    uart_txd <= 1'b0;
    repeat (4) @(posedge ref_clk);
    p1 <= 1'b1;
    tw_sda_low <= 1'b1;
    strap_sel <= 1'b0;
    @(negedge ref_clk);
    chk("tw_sda_in", 0, tw_sda_in);
    chk("uart_rxd", 0, uart_rxd);
    chk("pin2_oe", 1, pin2_oe);
    chk("tw_scl_in", 0, tw_scl_in);
    chk("pin1_out pin2_out", 2'b00, {pin1_out, pin2_out});
    chk("pin3", 2'b10, {pin3_oe, pin3_out});
    repeat (4) @(posedge ref_clk);
    cfg_wr_valid <= 1'b1;
    cfg_wr_data <= 16'h5A3C;
    tmode_wr_valid <= 1'b1;
    tmode_wr_data <= `HISC_TMODE_SURVEY;
    @(negedge ref_clk);
    chk("spi_mode", 0, spi_mode);
    chk("pin1_oe", 1, pin1_oe);
    @(posedge ref_clk);
    cfg_wr_valid <= 1'b0;
    tmode_wr_valid <= 1'b0;
    survey_done <= 1'b1;
    tw_sda_low <= 1'b0;
    @(posedge ref_clk);
    survey_done <= 1'b0;
    config_save_command <= 1'b1;
    @(posedge ref_clk);
    config_save_command <= 1'b0;
    repeat (80) @(posedge ref_clk);
    cfg_wr_valid <= 1'b1;
    cfg_wr_data <= 16'h0F0F;
    flash_cfg_valid <= 1'b1;
    flash_cfg_data <= saved[0][15:0];
    flash_tmode_data <= saved[0][17:16];
    @(negedge ref_clk);
    chk("tmode_state", `HISC_TMODE_FIXED, tmode_state);
    chk("cfg save", {14'h0, 2'h2, 16'h5A3C}, saved[0]);
    chk("osc save", 32'h1234ABCD, saved[1]);
    @(posedge ref_clk);
    cfg_wr_valid <= 1'b0;
    do_reset(1'b0);
    chk("cfg_active", 16'h5A3C, cfg_active);
    chk("tmode_state", `HISC_TMODE_FIXED, tmode_state);
    chk("spi_mode", 1, spi_mode);
    @(posedge ref_clk);
    tx_valid <= 1'b1;
    for (i = 0; i < 8; i++) begin
      tx_data <= 8'hA0 + i[7:0];
      @(posedge ref_clk);
    end
    tx_valid <= 1'b0;
    @(negedge ref_clk);
    chk("tx_ready full", 0, tx_ready);
    u_host.frame_start;
    chk("spi_ready", 1, spi_ready);
    for (i = 0; i < 9; i++) begin
      if (i == 8) begin
        @(posedge ref_clk);
        glitch_filter_en <= 1'b1;
        @(negedge ref_clk);
      end
      u_host.xfer(8'h30 + i[7:0], b);
      chk("miso byte", i < 8 ? 8'hA0 + i : `HISC_SPI_FILL, b);
    end
    u_host.frame_end;
    chk("tx_ready", 1, tx_ready);
    chk("rx count", 9, rxq.size());
    for (i = 0; i < 9; i++)
      chk("mosi byte", 8'h30 + i, rxq[i]);
    give_verdict;
  end
endmodule // hisc_top_tb
